// [hdl/cpl_cfg.svh]
`ifndef CPL_CFG_SVH
`define CPL_CFG_SVH

// ****************************************************************
// register offsets within one unit, byte addressed
// ****************************************************************
`define CPL_OFS_PTR 4'h0
`define CPL_OFS_STAT 4'h2
`define CPL_UNIT_SHIFT 2

// ****************************************************************
// coupler_status field positions
// ****************************************************************
`define CPL_SR_SPECIAL 15
`define CPL_SR_PARITY 14
`define CPL_SR_UNUSED 13
`define CPL_SR_REFUSED 12
`define CPL_SR_NOMEM 11
`define CPL_SR_NEEDBUF 10
`define CPL_SR_ADDR17 9
`define CPL_SR_ADDR16 8
`define CPL_SR_READY 7
`define CPL_SR_OFFLINE 6

// ****************************************************************
// command packet header field positions
// ****************************************************************
`define CPL_HDR_ACK 15
`define CPL_HDR_CVC 14
`define CPL_HDR_REVERSE 13
`define CPL_HDR_SWAP 12

// ****************************************************************
// reset values and termination classes
// ****************************************************************
`define CPL_RST_DMA 16'h0000
`define CPL_RST_UPPER 2'h0
`define CPL_TC_UNRECOV 3'h6

`endif

// [hdl/cpl_pkg.sv]
package cpl_pkg;

  typedef struct packed {
    logic sel;
    logic wr;
    logic rd;
    logic [1:0] be;
    logic [3:0] addr;
    logic [15:0] wdata;
  } cpl_host_req_t;

  typedef struct packed {
    logic [3:0] mode;
    logic [4:0] code;
    logic swap_bytes_flag;
    logic opposite_retry_direction;
  } cpl_hdr_t;

  typedef enum logic [1:0] {
    CPL_ST_IDLE = 2'b00,
    CPL_ST_ABORT = 2'b01,
    CPL_ST_WAIT = 2'b11
  } cpl_init_st_t;

endpackage

// [hdl/cpl_regs.sv]
`timescale 1ns/10ps
`include "cpl_cfg.svh"

// Summary of operation
// - unit uses two words chosen by switches
// - word pointer write loads address and upper bits
// - word pointer write clears ready
// - fetch packet, execute when acknowledge set
// - upper byte write loads both address bytes
// - lower byte write loads address and status
// - first address reads low DMA address
// - status write clears four error/ready bits
// - status write aborts, rewinds if online, then sets ready
// - status read returns whole status word
// - special flag set on nonzero termination class
// - parity flag reported, bit 13 reads zero
// - pointer write while not ready sets refused
// - nonexistent memory access sets its flag
// - needs-buffer flag until characteristics written
// - ready when idle, offline flag tracks transport
// - termination class encodes completion kind
// - classes 101 and 111 never reported from a completion
// - packet layouts per command kind
// - header clears volume check, reverses retry
// - header swap flag swaps data bytes
// - operation from command mode and code
module cpl_regs (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input cpl_pkg::cpl_host_req_t i_req,
  input wire logic [1:0] i_unit_sw,
  input wire logic i_offline_pin,
  input wire logic i_core_idle,
  input wire logic i_dma_load,
  input wire logic [17:0] i_dma_addr,
  input wire logic i_hdr_valid,
  input wire logic [15:0] i_hdr,
  input wire logic i_done,
  input wire logic [2:0] i_term_class,
  input wire logic i_parity_err,
  input wire logic i_nomem_err,
  input wire logic i_wchar_done,
  output logic [15:0] o_rdata,
  output logic o_rvalid,
  output logic o_fetch,
  output logic [17:0] o_fetch_addr,
  output logic o_abort,
  output logic o_rewind,
  output logic o_exec,
  output cpl_pkg::cpl_hdr_t o_hdr,
  output logic o_clear_vck
);
  import cpl_pkg::*;

  // ****************************************************************
  // input conditioning and address decode
  // ****************************************************************
  logic [1:0] unit_q;
  logic offline_q;
  logic [3:0] base;
  logic hit_ptr;
  logic hit_stat;
  logic ptr_word_wr;
  logic ptr_hi_wr;
  logic ptr_lo_wr;
  logic stat_wr;

  cpl_sync #(
    .W(3)
  ) u_sync (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_async({i_unit_sw, i_offline_pin}),
    .o_sync({unit_q, offline_q})
  );

  assign base = {unit_q, 2'b00};
  assign hit_ptr = i_req.sel && (i_req.addr == (base | `CPL_OFS_PTR));
  assign hit_stat = i_req.sel && (i_req.addr == (base | `CPL_OFS_STAT));
  assign ptr_word_wr = hit_ptr && i_req.wr && (i_req.be == 2'b11);
  assign ptr_hi_wr = hit_ptr && i_req.wr && (i_req.be == 2'b10);
  assign ptr_lo_wr = hit_ptr && i_req.wr && (i_req.be == 2'b01);
  assign stat_wr = hit_stat && i_req.wr && (i_req.be != 2'b00);

  // ****************************************************************
  // DMA address and upper address bits
  // ****************************************************************
  logic [15:0] dma_q;
  logic [1:0] upper_q;

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      dma_q <= `CPL_RST_DMA;
      upper_q <= `CPL_RST_UPPER;
    end
    else if (ptr_word_wr)
    begin
      // packets are word-quad aligned, so bits 1:0 carry address 17:16
      dma_q <= {i_req.wdata[15:2], 2'b00};
      upper_q <= i_req.wdata[1:0];
    end
    else if (ptr_hi_wr)
    begin
      dma_q <= {i_req.wdata[15:8], i_req.wdata[15:8]};
      upper_q <= i_req.wdata[9:8];
    end
    else if (ptr_lo_wr)
    begin
      dma_q[7:0] <= i_req.wdata[7:0];
    end
    else if (i_dma_load)
    begin
      dma_q <= i_dma_addr[15:0];
      upper_q <= i_dma_addr[17:16];
    end
  end

  // ****************************************************************
  // initialisation sequence
  // ****************************************************************
  cpl_init_st_t st_q;
  logic init_done;

  assign init_done = (st_q == CPL_ST_WAIT) && i_core_idle && !stat_wr;

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      st_q <= CPL_ST_IDLE;
    end
    else if (stat_wr)
    begin
      st_q <= CPL_ST_ABORT;
    end
    else
    begin
      unique case (st_q)
        CPL_ST_IDLE: st_q <= CPL_ST_IDLE;
        CPL_ST_ABORT: st_q <= CPL_ST_WAIT;
        CPL_ST_WAIT: st_q <= i_core_idle ? CPL_ST_IDLE : CPL_ST_WAIT;
        default: st_q <= CPL_ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_abort <= 1'b0;
      o_rewind <= 1'b0;
    end
    else
    begin
      o_abort <= (st_q == CPL_ST_ABORT);
      o_rewind <= (st_q == CPL_ST_ABORT) && !offline_q;
    end
  end

  // ****************************************************************
  // status flags
  // ****************************************************************
  logic ready_q;
  logic parity_q;
  logic refused_q;
  logic nomem_q;
  logic needbuf_q;
  logic special_q;
  logic [2:0] tc_q;
  logic [2:0] tc_in;

  // unused codes are folded into the unrecoverable class
  assign tc_in = (i_term_class[0] && i_term_class[2]) ? `CPL_TC_UNRECOV : i_term_class;

  // ready: init completion and command end set it; set wins the clear
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      ready_q <= 1'b0;
    end
    else if (init_done || (i_done && st_q == CPL_ST_IDLE))
    begin
      ready_q <= 1'b1;
    end
    else if (ptr_word_wr || stat_wr)
    begin
      ready_q <= 1'b0;
    end
    else if (ptr_lo_wr)
    begin
      ready_q <= i_req.wdata[`CPL_SR_READY];
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      parity_q <= 1'b0;
      nomem_q <= 1'b0;
      refused_q <= 1'b0;
    end
    else
    begin
      parity_q <= i_parity_err || (parity_q && !stat_wr);
      nomem_q <= i_nomem_err || (nomem_q && !stat_wr);
      refused_q <= (ptr_word_wr && !ready_q) || (refused_q && !stat_wr);
    end
  end

  // needs-buffer flag: every init re-arms it, even alongside a characteristics end
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      needbuf_q <= 1'b1;
    end
    else if (stat_wr)
    begin
      needbuf_q <= 1'b1;
    end
    else if (i_wchar_done)
    begin
      needbuf_q <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      tc_q <= 3'h0;
      special_q <= 1'b0;
    end
    else if (i_done)
    begin
      tc_q <= tc_in;
      special_q <= (tc_in != 3'h0);
    end
    else if (ptr_lo_wr)
    begin
      tc_q <= i_req.wdata[3:1];
    end
  end

  logic [15:0] status;
  assign status = {special_q, parity_q, 1'b0, refused_q, nomem_q, needbuf_q, upper_q,
                   ready_q, offline_q, 2'b00, tc_q, 1'b0};

  // ****************************************************************
  // host read port
  // ****************************************************************
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_rdata <= 16'h0000;
      o_rvalid <= 1'b0;
    end
    else
    begin
      o_rvalid <= (hit_ptr || hit_stat) && i_req.rd;
      if (hit_ptr && i_req.rd)
      begin
        o_rdata <= dma_q;
      end
      else
      begin
        o_rdata <= (hit_stat && i_req.rd) ? status : 16'h0000;
      end
    end
  end

  // ****************************************************************
  // packet fetch and header decode
  // ****************************************************************
  // a pointer write while not ready is refused and starts no fetch
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_fetch <= 1'b0;
      o_fetch_addr <= 18'h00000;
    end
    else
    begin
      o_fetch <= ptr_word_wr && ready_q;
      if (ptr_word_wr)
      begin
        o_fetch_addr <= {i_req.wdata[1:0], i_req.wdata[15:2], 2'b00};
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_exec <= 1'b0;
      o_clear_vck <= 1'b0;
      o_hdr <= '0;
    end
    else
    begin
      o_exec <= i_hdr_valid && i_hdr[`CPL_HDR_ACK];
      o_clear_vck <= i_hdr_valid && i_hdr[`CPL_HDR_ACK] && i_hdr[`CPL_HDR_CVC];
      if (i_hdr_valid && i_hdr[`CPL_HDR_ACK])
      begin
        o_hdr.mode <= i_hdr[11:8];
        o_hdr.code <= i_hdr[4:0];
        o_hdr.swap_bytes_flag <= i_hdr[`CPL_HDR_SWAP];
        o_hdr.opposite_retry_direction <= i_hdr[`CPL_HDR_REVERSE];
      end
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  a_ptr_word_load: assert property (ptr_word_wr |=>
    dma_q == {$past(i_req.wdata[15:2]), 2'b00})
    else $error("pointer word write did not load DMA address");
  a_upper_bits: assert property (ptr_word_wr |=> status[9:8] == $past(i_req.wdata[1:0]))
    else $error("upper address bits not loaded from pointer write");
  a_ready_cleared: assert property (ptr_word_wr && !init_done && !i_done |=> !ready_q)
    else $error("ready not cleared by pointer write");
  a_fetch_gated: assert property (o_fetch |-> $past(ptr_word_wr && ready_q))
    else $error("fetch without accepted pointer write");
  a_hi_byte_dup: assert property (ptr_hi_wr |=>
    dma_q == {2{$past(i_req.wdata[15:8])}} && upper_q == $past(i_req.wdata[9:8]))
    else $error("upper byte write did not fill both bytes");
  a_status_clear: assert property (stat_wr && !i_parity_err && !i_nomem_err
    |=> !parity_q && !nomem_q && !refused_q && needbuf_q && (!ready_q || $past(i_done)))
    else $error("status write did not clear flags");
  a_init_abort: assert property (stat_wr ##1 !stat_wr |=> o_abort)
    else $error("status write did not abort");
  a_init_ready: assert property (init_done |=> ready_q)
    else $error("ready not set after init");
  a_rewind_online: assert property (o_rewind |-> o_abort && !$past(offline_q))
    else $error("rewind issued while offline");
  a_zero_bits: assert property (status[13] == 1'b0 && status[5:4] == 2'b00 && !status[0])
    else $error("unsupported status bits not zero");
  a_no_bad_class: assert property (i_done |=> tc_q != 3'h5 && tc_q != 3'h7)
    else $error("unused termination class reported");
  a_special_flag: assert property (i_done |=> special_q == ($past(i_term_class) != 3'h0))
    else $error("special condition flag inconsistent");
  a_refused: assert property (ptr_word_wr && !ready_q |=> refused_q)
    else $error("refused modification flag not set");
  a_nomem_set: assert property (i_nomem_err |=> nomem_q)
    else $error("nonexistent memory flag not set");
  a_needbuf_cleared: assert property (i_wchar_done && !stat_wr |=> !needbuf_q)
    else $error("needs buffer flag not cleared");
  a_exec_ack: assert property (o_exec |-> $past(i_hdr_valid && i_hdr[15]))
    else $error("execution without acknowledge bit");

endmodule // cpl_regs

// [hdl/cpl_sync.sv]
`timescale 1ns/10ps

module cpl_sync #(
  parameter int W = 1
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);

  logic [W-1:0] ff1_q;
  logic [W-1:0] ff2_q;
  logic [W-1:0] ff3_q;

  if (W < 1)
  begin : g_chk
    $error("cpl_sync: width must be at least one");
  end

  // a change is taken only once the last two stages agree
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      ff1_q <= '0;
      ff2_q <= '0;
      ff3_q <= '0;
      o_sync <= '0;
    end
    else
    begin
      ff1_q <= i_async;
      ff2_q <= ff1_q;
      ff3_q <= ff2_q;
      for (int i = 0; i < W; i++)
      begin
        if (ff2_q[i] == ff3_q[i])
        begin
          o_sync[i] <= ff3_q[i];
        end
      end
    end
  end

endmodule // cpl_sync

// [sim/cpl_host_model.sv]
`timescale 1ns/10ps

// ****************************************************************
// host bus master, drives just after the falling edge
// ****************************************************************
module cpl_host_model (
  input wire logic i_clk,
  input wire logic [15:0] i_rdata,
  input wire logic i_rvalid,
  output cpl_pkg::cpl_host_req_t o_req
);
  import cpl_pkg::*;

  initial o_req = '0;

  // released bus shows inverted data, never a stale copy
  task automatic wr(input logic [3:0] a, input logic [1:0] be, input logic [15:0] d);
  begin
    @(negedge i_clk);
    o_req = {3'b110, be, a, d};
    @(negedge i_clk);
    o_req = {3'b000, 2'b00, ~a, ~d};
  end
  endtask

  task automatic rd(input logic [3:0] a, output logic [15:0] d, output logic ok);
  begin
    ok = 1'b0;
    d = 16'h0000;
    @(negedge i_clk);
    o_req = {3'b101, 2'b00, a, 16'h5a5a};
    for (int n = 0; n < 3 && !ok; n++)
    begin
      @(negedge i_clk);
      o_req = {3'b000, 2'b00, ~a, 16'ha5a5};
      if (i_rvalid === 1'b1)
      begin
        ok = 1'b1;
        d = i_rdata;
      end
    end
  end
  endtask

  // packet address bits 1:0 must be zero, low bits carry the upper bits
  task automatic ptr(input logic [3:0] a, input logic [17:0] p);
    wr(a, 2'b11, {p[15:2], p[17:16]});
  endtask
endmodule // cpl_host_model

// [sim/cpl_regs_tb.sv]
`timescale 1ns/10ps

`define CHK(a, b) \
  begin check_count++; if ((a) !== (b)) begin failures++; \
  $display("wrong value at %0t: got %h want %h", $time, (a), (b)); end end

// ****************************************************************
// register bank bench
// ****************************************************************
module cpl_regs_tb;
  import cpl_pkg::*;

  int failures = 0;
  int check_count = 0;
  logic i_clk = 1'b0;
  logic i_rst_b = 1'b0;
  cpl_host_req_t req;
  logic [1:0] unit_sw = 2'h0;
  logic offline = 1'b0;
  logic idle = 1'b0;
  logic dma_load = 1'b0;
  logic [17:0] dma_addr = 18'h00000;
  logic hdr_valid = 1'b0;
  logic [15:0] hdr = 16'h0000;
  logic done = 1'b0;
  logic [2:0] tc = 3'h0;
  logic perr = 1'b0;
  logic nomem = 1'b0;
  logic wchar = 1'b0;
  logic [15:0] rdata;
  logic rvalid, fetch, abort, rewind, exec, clr_vck;
  logic [17:0] fetch_addr;
  cpl_hdr_t hdr_o;
  logic [15:0] d;
  logic ok;
  logic [2:0] c;

  always #5 i_clk = ~i_clk;

  cpl_host_model cpl_host_model_inst (.i_clk(i_clk), .i_rdata(rdata), .i_rvalid(rvalid),
    .o_req(req));

  cpl_regs cpl_regs_inst (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_req(req),
    .i_unit_sw(unit_sw), .i_offline_pin(offline), .i_core_idle(idle),
    .i_dma_load(dma_load), .i_dma_addr(dma_addr), .i_hdr_valid(hdr_valid), .i_hdr(hdr),
    .i_done(done), .i_term_class(tc), .i_parity_err(perr), .i_nomem_err(nomem),
    .i_wchar_done(wchar), .o_rdata(rdata), .o_rvalid(rvalid), .o_fetch(fetch),
    .o_fetch_addr(fetch_addr), .o_abort(abort), .o_rewind(rewind), .o_exec(exec),
    .o_hdr(hdr_o), .o_clear_vck(clr_vck));

  task automatic test_done;
  begin
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  end
  endtask

  task automatic rc(input logic [3:0] a, input logic [15:0] m, input logic [15:0] e);
    logic [15:0] v;
    logic k;
  begin
    cpl_host_model_inst.rd(a, v, k);
    `CHK(k, 1'b1)
    `CHK(v & m, e)
  end
  endtask

  // status write starts init; rw says whether a rewind is due
  task automatic init(input logic [3:0] b, input logic rw);
    int n;
    logic [15:0] e;
  begin
    idle = 1'b0;
    n = 0;
    e = rw ? 16'h0400 : 16'h0440;
    cpl_host_model_inst.wr(b + 4'h2, 2'b11, 16'hffff);
    while (abort !== 1'b1 && n < 8)
    begin
      @(negedge i_clk);
      n++;
    end
    if (n == 8)
    begin
      failures++;
      test_done();
    end
    `CHK(rewind, rw)
    rc(b + 4'h2, 16'h7cc1, e);
    idle = 1'b1;
    repeat (3) @(negedge i_clk);
    rc(b + 4'h2, 16'h7cc1, e | 16'h0080);
  end
  endtask

  task automatic hd(input logic [15:0] h, input logic x, input cpl_hdr_t e, input logic v);
  begin
    @(negedge i_clk);
    hdr = h;
    hdr_valid = 1'b1;
    @(negedge i_clk);
    hdr_valid = 1'b0;
    hdr = ~h;
    `CHK(exec, x)
    `CHK(clr_vck, v)
    `CHK(hdr_o, e)
  end
  endtask

  initial
  begin
    repeat (20000) @(posedge i_clk);
    failures++;
    test_done();
  end

  initial
  begin
    repeat (6) @(negedge i_clk);
    i_rst_b = 1'b1;
    repeat (6) @(negedge i_clk);
    rc(4'h2, 16'hffff, 16'h0400);
    init(4'h0, 1'b1);
    cpl_host_model_inst.ptr(4'h0, 18'h11234);
    `CHK(fetch, 1'b1)
    `CHK(fetch_addr, 18'h11234)
    rc(4'h0, 16'hffff, 16'h1234);
    rc(4'h2, 16'h1380, 16'h0100);
    cpl_host_model_inst.ptr(4'h0, 18'h00008);
    `CHK(fetch, 1'b0)
    rc(4'h2, 16'h1300, 16'h1000);
    hd(16'hd305, 1'b1, '{4'h3, 5'h05, 1'b1, 1'b0}, 1'b1);
    hd(16'h6a10, 1'b0, '{4'h3, 5'h05, 1'b1, 1'b0}, 1'b0);
    hd(16'ha10a, 1'b1, '{4'h1, 5'h0a, 1'b0, 1'b1}, 1'b0);
    // every class code, including the two that must be remapped
    for (int t = 0; t < 8; t++)
    begin
      @(negedge i_clk);
      tc = t[2:0];
      done = 1'b1;
      @(negedge i_clk);
      done = 1'b0;
      c = (t == 5 || t == 7) ? 3'h6 : t[2:0];
      rc(4'h2, 16'h808f, {c != 3'h0, 7'h00, 1'b1, 3'h0, c, 1'b0});
    end
    @(negedge i_clk);
    tc = 3'h0;
    done = 1'b1;
    perr = 1'b1;
    nomem = 1'b1;
    wchar = 1'b1;
    @(negedge i_clk);
    {done, perr, nomem, wchar} = 4'h0;
    rc(4'h2, 16'h6c00, 16'h4800);
    init(4'h0, 1'b1);
    @(negedge i_clk);
    dma_addr = 18'h2abcd;
    dma_load = 1'b1;
    @(negedge i_clk);
    dma_load = 1'b0;
    rc(4'h0, 16'hffff, 16'habcd);
    cpl_host_model_inst.wr(4'h0, 2'b10, 16'hab03);
    rc(4'h0, 16'hffff, 16'habab);
    rc(4'h2, 16'h0300, 16'h0300);
    init(4'h0, 1'b1);
    cpl_host_model_inst.wr(4'h0, 2'b01, 16'h338c);
    rc(4'h0, 16'hffff, 16'hab8c);
    rc(4'h2, 16'h00ff, 16'h008c);
    init(4'h0, 1'b1);
    offline = 1'b1;
    repeat (8) @(negedge i_clk);
    init(4'h0, 1'b0);
    offline = 1'b0;
    unit_sw = 2'h2;
    repeat (8) @(negedge i_clk);
    rc(4'ha, 16'h0040, 16'h0000);
    rc(4'h8, 16'hffff, 16'hab8c);
    cpl_host_model_inst.rd(4'h2, d, ok);
    `CHK(ok, 1'b0)
    test_done();
  end
endmodule // cpl_regs_tb
